//--- inc/misc_cfg_pkg.sv
// constants, types and decode tables for the misc configuration slice
package misc_cfg_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] LTO_SLT_OFS = 8'h58;
  localparam logic [7:0] ODIAG_OFS   = 8'h59;
  localparam logic [7:0] WDOG_OFS    = 8'h5A;
  localparam logic [7:0] SHORT_OFS   = 8'h5B;
  localparam logic [7:0] CLR_OFS     = 8'h60;
  localparam logic [7:0] STAT_OFS    = 8'h68;
  localparam logic [7:0] MASK_OFS    = 8'h69;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int LTO_LSB  = 4;
  localparam int SLT_LSB  = 0;
  localparam int ODC_LSB  = 4;
  localparam int ODPW_LSB = 0;
  localparam int WDS_LSB  = 4;
  localparam int FORCE_FS_BIT  = 5;
  localparam int RESTORE_BIT   = 4;
  localparam int FORCE_ERR_BIT = 3;
  localparam int EXIT_FS_BIT   = 2;
  localparam int CLEAR_FAULT_FLAGS_BIT = 1;
  localparam int CLEAR_POWERON_FLAG_BIT   = 0;

  // interrupt status bits
  localparam int EV_ENTER   = 0;
  localparam int EV_EXIT    = 1;
  localparam int EV_WD      = 2;
  localparam int EV_REFUSED = 3;
  localparam int EV_W       = 4;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [7:0] CLR_RST  = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam logic [4:0] SLT_BASE_V = 5'h05;
  localparam logic [3:0] ODC_CHAN_CODE = 4'hF;
  localparam logic [3:0] WD_IMM_CODE   = 4'hC;

  // periods in microseconds
  localparam int LTO_US [8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 10000};
  localparam int ODPW_US [16] = '{100, 20, 30, 50, 80, 150, 200, 300,
                                  500, 800, 1000, 1200, 1500, 2000, 3000, 5000};
  localparam int WD_US [16] = '{0, 200, 500, 1000, 2000, 5000, 10000, 20000,
                                50000, 100000, 200000, 500000, 0, 0, 0, 0};

  typedef enum logic [1:0] {
    ST_NORMAL   = 2'b01,
    ST_FAILSAFE = 2'b10
  } fs_state_t;

  function automatic logic wd_immediate(input logic [3:0] sel);
    return sel >= WD_IMM_CODE;
  endfunction

  function automatic logic [31:0] wd_period_us(input logic [3:0] sel);
    return 32'(WD_US[sel]);
  endfunction

endpackage

//--- inc/core_if.sv
// watchdog and interrupt signals shared inside the config slice
interface core_if;
  logic [3:0]                 wd_sel;
  logic                       kick;
  logic                       failsafe;
  logic                       expire;
  logic [misc_cfg_pkg::EV_W-1:0] events;
  logic [misc_cfg_pkg::EV_W-1:0] mask;
  logic                       status_rd;
  logic [misc_cfg_pkg::EV_W-1:0] status;
  logic                       irq;

  modport top (output wd_sel, kick, failsafe, events, mask, status_rd,
               input expire, status, irq);
  modport wd  (input wd_sel, kick, failsafe, output expire);
  modport ic  (input events, mask, status_rd, output status, irq);
endinterface

//--- verilog/wd_timer.sv
// link inactivity watchdog counter
module wd_timer #(
  parameter int CYC_US = misc_cfg_pkg::CYC_PER_US
) (
  input wire logic ref_clk,
  input wire logic resetn,
  core_if.wd       w
);
  import misc_cfg_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        expire;
  } wd_st_t;

  wd_st_t s, n;
  logic [31:0] period;

  // ------------------------------------------------------------
  // counting
  // ------------------------------------------------------------
  always_comb begin
    period   = 32'(wd_period_us(w.wd_sel) * CYC_US);
    n        = s;
    n.expire = 1'b0;
    if (w.kick || w.failsafe || period == 32'h0000_0000) begin
      n.cnt = 32'h0000_0000;
    end else if (s.cnt >= period - 32'h0000_0001) begin
      n.cnt    = 32'h0000_0000;
      n.expire = 1'b1;
    end else begin
      n.cnt = s.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign w.expire = s.expire;
endmodule

//--- verilog/irq_ctrl.sv
// sticky event status, enable mask and level interrupt
module irq_ctrl (
  input wire logic ref_clk,
  input wire logic resetn,
  core_if.ic       c
);
  import misc_cfg_pkg::*;

  typedef struct packed {
    logic [EV_W-1:0] status;
    logic            irq;
  } ic_st_t;

  ic_st_t s, n;

  // ------------------------------------------------------------
  // status and interrupt
  // ------------------------------------------------------------
  always_comb begin
    n = s;
    // new events win over the clear on read
    n.status = (c.status_rd ? '0 : s.status) | c.events;
    n.irq    = |(n.status & c.mask);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign c.status = s.status;
  assign c.irq    = s.irq;
endmodule

//--- verilog/misc_cfg_regs.sv
// misc configuration, watchdog period and clear/command registers
//
// Implementation choice: strobed register access.

module misc_cfg_regs #(
  parameter int CYC_US = misc_cfg_pkg::CYC_PER_US
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] nv_link_timeout_copy,
  input  wire logic [3:0] nv_supply_low_threshold,
  input  wire logic [3:0] nv_ondemand_diag_current,
  input  wire logic [3:0] nv_ondemand_diag_pulse_width,
  input  wire logic [3:0] nv_watchdog_period_sel,
  input  wire logic [7:0] nv_short_detect_threshold,
  input  wire logic       clear_reg_write_protect,
  output logic      [2:0] link_timeout_sel,
  output logic     [13:0] link_timeout_us,
  output logic      [3:0] supply_low_threshold,
  output logic      [4:0] supply_low_volts,
  output logic      [3:0] ondemand_diag_current,
  output logic      [5:0] diag_current_num,
  output logic            diag_use_channel_current,
  output logic      [3:0] ondemand_diag_pulse_width,
  output logic     [12:0] diag_pulse_us,
  output logic      [3:0] watchdog_period_sel,
  output logic      [7:0] short_detect_threshold,
  output logic            failsafe_active,
  output logic            clear_fault_flags_pulse,
  output logic            clear_poweron_flag_pulse,
  output logic            force_error_pin_pulse,
  output logic            restore_defaults_pulse,
  output logic            irq
);
  import misc_cfg_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    // set by reset, pulls the nv copies in at the first edge
    logic            load_pend;
    logic [2:0]      lto;
    logic [3:0]      slt;
    logic [3:0]      odc;
    logic [3:0]      odpw;
    logic [3:0]      wds;
    logic [7:0]      sdt;
    // decoded copies of the fields
    logic [13:0]     lto_us;
    logic [4:0]      slt_v;
    logic [5:0]      odc_num;
    logic            odc_chan;
    logic [12:0]     odpw_us;
    fs_state_t       state;
    // registered copy so the output comes from a flop
    logic            fs_out;
    logic            clear_fault_flags;
    logic            clear_poweron_flag;
    logic            force_err;
    logic            restore;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] mask;
    // stands one cycle after a read, zero otherwise
    logic [7:0]      rdata;
  } st_t;

  st_t s, n;

  // watchdog and interrupt blocks share one bundle
  core_if c ();

  // command decode helpers
  logic       wr_clr;
  logic       clr_ok;
  logic       reload;
  logic       go_fs;
  logic       go_normal;
  logic [7:0] cmd;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic bus_hit(input logic       strobe,
                                   input logic [7:0] ad,
                                   input logic [7:0] ofs);
    return strobe && (ad == ofs);
  endfunction

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  // CYC_US scales every watchdog period
  wd_timer #(
    .CYC_US (CYC_US)
  ) u_wd (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .w       (c)
  );

  // sticky status and the level interrupt
  irq_ctrl u_ic (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .c       (c)
  );

  assign c.wd_sel    = s.wds;
  // any access stands in for link traffic
  assign c.kick      = reg_wr | reg_rd;
  assign c.failsafe  = (s.state == ST_FAILSAFE);
  assign c.events    = s.ev;
  assign c.mask      = s.mask;
  // reading status also clears it
  assign c.status_rd = bus_hit(reg_rd, reg_addr, STAT_OFS);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n           = s;
    // pulses, events and read data last one cycle
    n.load_pend = 1'b0;
    n.clear_fault_flags = 1'b0;
    n.clear_poweron_flag   = 1'b0;
    n.force_err = 1'b0;
    n.restore   = 1'b0;
    n.ev        = '0;
    n.rdata     = 8'h00;

    wr_clr = bus_hit(reg_wr, reg_addr, CLR_OFS);
    clr_ok = wr_clr && !clear_reg_write_protect;
    // reserved command bits reach no action
    cmd    = clr_ok ? (reg_wdata & ~CLR_RST) : 8'h00;
    // a refused write still leaves a status trace
    if (wr_clr && clear_reg_write_protect) begin
      n.ev[EV_REFUSED] = 1'b1;
    end

    n.clear_fault_flags = cmd[CLEAR_FAULT_FLAGS_BIT];
    n.clear_poweron_flag   = cmd[CLEAR_POWERON_FLAG_BIT];
    n.force_err = cmd[FORCE_ERR_BIT];
    n.restore   = cmd[RESTORE_BIT];

    // register writes, reserved bits dropped
    if (reg_wr) begin
      case (reg_addr)
        LTO_SLT_OFS: begin
          n.lto = reg_wdata[LTO_LSB +: 3];
          n.slt = reg_wdata[SLT_LSB +: 4];
        end
        ODIAG_OFS: begin
          n.odc  = reg_wdata[ODC_LSB +: 4];
          n.odpw = reg_wdata[ODPW_LSB +: 4];
        end
        WDOG_OFS: begin
          n.wds = reg_wdata[WDS_LSB +: 4];
        end
        SHORT_OFS: begin
          n.sdt = reg_wdata;
        end
        MASK_OFS: begin
          n.mask = reg_wdata[EV_W-1:0];
        end
        // unmapped offsets are ignored
        default: begin
          n.mask = s.mask;
        end
      endcase
    end

    // nonvolatile load, also on restore
    // restore reloads in the same edge as its pulse
    reload = s.load_pend || cmd[RESTORE_BIT];
    if (reload) begin
      n.lto = nv_link_timeout_copy;
      n.slt = nv_supply_low_threshold;
      n.odc = nv_ondemand_diag_current;
      n.odpw = nv_ondemand_diag_pulse_width;
      n.wds = nv_watchdog_period_sel;
      n.sdt = nv_short_detect_threshold;
      n.mask = MASK_RST;
    end

    // decoded values follow the fields
    n.lto_us   = 14'(LTO_US[n.lto]);
    n.slt_v    = SLT_BASE_V + {1'b0, n.slt};
    n.odc_num  = {n.odc, 2'b00} + 6'h01;
    n.odc_chan = (n.odc == ODC_CHAN_CODE);
    n.odpw_us  = 13'(ODPW_US[n.odpw]);

    // fail-safe state machine
    // forced entry
    go_fs     = cmd[FORCE_FS_BIT] || c.expire || wd_immediate(s.wds);
    // exit request
    // any entry cause wins over a same-cycle exit
    go_normal = cmd[EXIT_FS_BIT] && !go_fs;
    n.ev[EV_WD] = c.expire;
    case (s.state)
      ST_NORMAL: begin
        if (go_fs) begin
          n.state         = ST_FAILSAFE;
          n.ev[EV_ENTER]  = 1'b1;
        end
      end
      ST_FAILSAFE: begin
        if (go_normal) begin
          n.state        = ST_NORMAL;
          n.ev[EV_EXIT]  = 1'b1;
        end
      end
      default: begin
        n.state = ST_NORMAL;
      end
    endcase
    n.fs_out = (n.state == ST_FAILSAFE);

    if (reg_rd) begin
      case (reg_addr)
        LTO_SLT_OFS: n.rdata = {1'b0, s.lto, s.slt};
        ODIAG_OFS:   n.rdata = {s.odc, s.odpw};
        WDOG_OFS:    n.rdata = {s.wds, 4'h0};
        SHORT_OFS:   n.rdata = s.sdt;
        // command bits always read back zero
        CLR_OFS:     n.rdata = CLR_RST;
        // status read clears it in the interrupt block
        STAT_OFS:    n.rdata = {4'h0, c.status};
        MASK_OFS:    n.rdata = {4'h0, s.mask};
        default:     n.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s           <= '0;
      // nv copies load at the first edge after release
      s.load_pend <= 1'b1;
      s.state     <= ST_NORMAL;
      s.mask      <= MASK_RST;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata                 = s.rdata;
  assign link_timeout_sel          = s.lto;
  assign link_timeout_us           = s.lto_us;
  assign supply_low_threshold      = s.slt;
  assign supply_low_volts          = s.slt_v;
  assign ondemand_diag_current     = s.odc;
  assign diag_current_num          = s.odc_num;
  assign diag_use_channel_current  = s.odc_chan;
  assign ondemand_diag_pulse_width = s.odpw;
  assign diag_pulse_us             = s.odpw_us;
  assign watchdog_period_sel       = s.wds;
  assign short_detect_threshold    = s.sdt;
  assign failsafe_active           = s.fs_out;
  assign clear_fault_flags_pulse   = s.clear_fault_flags;
  assign clear_poweron_flag_pulse  = s.clear_poweron_flag;
  assign force_error_pin_pulse     = s.force_err;
  assign restore_defaults_pulse    = s.restore;
  assign irq                       = c.irq;

endmodule

//--- verification/misc_cfg_assertions.sv
// concurrent checks on the misc configuration register slice
module misc_cfg_assertions
  import misc_cfg_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       clear_reg_write_protect,
  input wire logic [2:0] link_timeout_sel,
  input wire logic [3:0] supply_low_threshold,
  input wire logic [3:0] watchdog_period_sel,
  input wire logic       failsafe_active,
  input wire logic       clear_fault_flags_pulse,
  input wire logic       clear_poweron_flag_pulse,
  input wire logic       force_error_pin_pulse,
  input wire logic       restore_defaults_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clr_wr;
  logic por_req;
  assign clr_wr  = reg_wr && reg_addr == CLR_OFS && !clear_reg_write_protect;
  assign por_req = clr_wr && reg_wdata[CLEAR_POWERON_FLAG_BIT];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  read_idle_zero_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  timeout_layout_a:
    assert property (reg_rd && reg_addr == LTO_SLT_OFS |=>
      reg_rdata == {1'b0, link_timeout_sel, supply_low_threshold}) else $error("58h layout");
  wdog_layout_a:
    assert property (reg_rd && reg_addr == WDOG_OFS |=>
      reg_rdata == {watchdog_period_sel, 4'h0}) else $error("5Ah layout");
  fault_clear_pulse_a:
    assert property (clr_wr && reg_wdata[CLEAR_FAULT_FLAGS_BIT] |=> clear_fault_flags_pulse)
      else $error("fault clear pulse missing");
  por_pulse_cause_a:
    assert property (clear_poweron_flag_pulse |-> $past(por_req)) else $error("stray pulse");
  protect_block_a:
    assert property (reg_wr && reg_addr == CLR_OFS && clear_reg_write_protect |=>
      !(clear_fault_flags_pulse || clear_poweron_flag_pulse || force_error_pin_pulse
        || restore_defaults_pulse)) else $error("protected write acted");
  force_enter_a:
    assert property (clr_wr && reg_wdata[FORCE_FS_BIT] |=> failsafe_active)
      else $error("force fail-safe ignored");
  exit_leave_a:
    assert property (clr_wr && reg_wdata[EXIT_FS_BIT] && !reg_wdata[FORCE_FS_BIT]
      && !reg_wdata[RESTORE_BIT] && watchdog_period_sel < WD_IMM_CODE |=> !failsafe_active)
      else $error("exit fail-safe ignored");
  wd_immediate_a:
    assert property (watchdog_period_sel >= WD_IMM_CODE |=> failsafe_active)
      else $error("immediate code not in fail-safe");
  wd_disabled_a:
    assert property (watchdog_period_sel == 4'h0 && !failsafe_active
      && !(clr_wr && reg_wdata[FORCE_FS_BIT]) |=> !failsafe_active)
      else $error("disabled watchdog entered fail-safe");
endmodule

bind misc_cfg_regs misc_cfg_assertions chk_u (
  .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .clear_reg_write_protect, .link_timeout_sel, .supply_low_threshold, .watchdog_period_sel,
  .failsafe_active, .clear_fault_flags_pulse, .clear_poweron_flag_pulse,
  .force_error_pin_pulse, .restore_defaults_pulse
);

//--- verification/host_model.sv
// register bus master standing in for the host controller
module host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one write cycle, bus scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask
endmodule

//--- verification/led_driver_misc_config_clear_regs_tb.sv
// self-checking bench for the misc configuration register slice
module led_driver_misc_config_clear_regs_tb
  import misc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals and expectations
  // ----------------------------------------
  localparam int LTO_E [8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 10000};
  localparam int PW_E [16] = '{100, 20, 30, 50, 80, 150, 200, 300,
                               500, 800, 1000, 1200, 1500, 2000, 3000, 5000};
  localparam int WD_E [4] = '{0, 200, 500, 1000};
  logic        ref_clk, resetn, reg_wr, reg_rd, clear_reg_write_protect, irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, short_detect_threshold;
  logic [7:0]  nv_short_detect_threshold, a, v, d;
  logic [2:0]  nv_link_timeout_copy, link_timeout_sel;
  logic [3:0]  nv_supply_low_threshold, nv_ondemand_diag_current, nv_watchdog_period_sel;
  logic [3:0]  nv_ondemand_diag_pulse_width, supply_low_threshold, ondemand_diag_current;
  logic [3:0]  ondemand_diag_pulse_width, watchdog_period_sel, pulses;
  logic [13:0] link_timeout_us;
  logic [12:0] diag_pulse_us;
  logic [5:0]  diag_current_num;
  logic [4:0]  supply_low_volts;
  logic        diag_use_channel_current, failsafe_active, clear_fault_flags_pulse;
  logic        clear_poweron_flag_pulse, force_error_pin_pulse, restore_defaults_pulse;
  logic [7:0]  sh [4];
  logic [31:0] seed = 32'h8cbc_a859;
  int          errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  assign pulses = {clear_fault_flags_pulse, clear_poweron_flag_pulse,
                   force_error_pin_pulse, restore_defaults_pulse};

  misc_cfg_regs #(.CYC_US(1)) dut_u (
    .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .nv_link_timeout_copy, .nv_supply_low_threshold, .nv_ondemand_diag_current,
    .nv_ondemand_diag_pulse_width, .nv_watchdog_period_sel, .nv_short_detect_threshold,
    .clear_reg_write_protect, .link_timeout_sel, .link_timeout_us, .supply_low_threshold,
    .supply_low_volts, .ondemand_diag_current, .diag_current_num, .diag_use_channel_current,
    .ondemand_diag_pulse_width, .diag_pulse_us, .watchdog_period_sel, .short_detect_threshold,
    .failsafe_active, .clear_fault_flags_pulse, .clear_poweron_flag_pulse,
    .force_error_pin_pulse, .restore_defaults_pulse, .irq
  );
  host_model host_u (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  function automatic logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] exp_rb(input logic [7:0] ad, input logic [7:0] val);
    case (ad)
      LTO_SLT_OFS:          return val & 8'h7f;
      WDOG_OFS:             return val & 8'hf0;
      ODIAG_OFS, SHORT_OFS: return val;
      default:              return 8'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic load_nv;
    sh[0] = {1'b0, nv_link_timeout_copy, nv_supply_low_threshold};
    sh[1] = {nv_ondemand_diag_current, nv_ondemand_diag_pulse_width};
    sh[2] = {nv_watchdog_period_sel, 4'h0};
    sh[3] = nv_short_detect_threshold;
  endtask
  task automatic check_all;
    for (int k = 0; k < 4; k++) begin
      host_u.rd(LTO_SLT_OFS + 8'(k), d);
      chk("register value", sh[k], d);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    clear_reg_write_protect = 1'b1;
    nv_link_timeout_copy = 3'(rnd8());
    nv_supply_low_threshold = 4'(rnd8());
    nv_ondemand_diag_current = 4'(rnd8());
    nv_ondemand_diag_pulse_width = 4'(rnd8());
    nv_watchdog_period_sel = 4'(rnd8() % 8'd12);
    nv_short_detect_threshold = rnd8();
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    load_nv();
    check_all();
    host_u.rd(CLR_OFS, d);
    chk("command reset", 8'h00, d);
    for (int i = 0; i < 40; i++) begin
      a = (rnd8() % 8'd5 == 8'd4) ? 8'h5c : LTO_SLT_OFS + (rnd8() & 8'h03);
      v = rnd8();
      if (a == WDOG_OFS) v[7:4] = 4'(v[7:4] % 4'd12);
      // corner: channel current code on the first pass
      if (i == 0) begin
        a = ODIAG_OFS;
        v = 8'hf5;
      end
      host_u.wr(a, v);
      host_u.rd(a, d);
      chk("readback", exp_rb(a, v), d);
      if (a != 8'h5c) sh[a[1:0]] = exp_rb(a, v);
      chk("timeout us", LTO_E[sh[0][6:4]], link_timeout_us);
      chk("supply volts", 5 + sh[0][3:0], supply_low_volts);
      chk("pulse us", PW_E[sh[1][3:0]], diag_pulse_us);
      chk("channel current", sh[1][7:4] == 4'hf, diag_use_channel_current);
      if (sh[1][7:4] != 4'hf) chk("current num", sh[1][7:4] * 4 + 1, diag_current_num);
      chk("short threshold", sh[3], short_detect_threshold);
      chk("misc2 fields", sh[0], {1'b0, link_timeout_sel, supply_low_threshold});
      chk("diag fields", sh[1], {ondemand_diag_current, ondemand_diag_pulse_width});
      chk("wd field", sh[2][7:4], watchdog_period_sel);
    end
    host_u.wr(CLR_OFS, 8'h3f);
    chk("locked pulses", 5'h00, {pulses, failsafe_active});
    host_u.rd(STAT_OFS, d);
    chk("refused status", 8'h08, d & 8'h08);
    @(posedge ref_clk) clear_reg_write_protect <= 1'b0;
    for (int b = 0; b < 5; b++) begin
      host_u.wr(CLR_OFS, 8'(1 << b));
      chk("pulses", {b == 1, b == 0, b == 3, b == 4}, pulses);
      @(posedge ref_clk);
      #1;
      chk("pulse ends", 4'h0, pulses);
      host_u.rd(CLR_OFS, d);
      chk("self clear", 8'h00, d);
    end
    load_nv();
    check_all();
    host_u.wr(WDOG_OFS, 8'h00);
    host_u.wr(CLR_OFS, 8'hc0);
    chk("reserved bits", 5'h00, {pulses, failsafe_active});
    host_u.wr(CLR_OFS, 8'h20);
    chk("force entry", 1'b1, failsafe_active);
    host_u.wr(CLR_OFS, 8'h04);
    chk("exit", 1'b0, failsafe_active);
    for (int c = 12; c < 16; c++) begin
      host_u.wr(WDOG_OFS, 8'(c << 4));
      @(posedge ref_clk);
      #1;
      chk("wd immediate", 1'b1, failsafe_active);
      host_u.wr(CLR_OFS, 8'h04);
      chk("exit refused", 1'b1, failsafe_active);
      host_u.wr(WDOG_OFS, 8'h00);
      host_u.wr(CLR_OFS, 8'h04);
      chk("exit ok", 1'b0, failsafe_active);
    end
    repeat (300) @(posedge ref_clk);
    #1;
    chk("wd off", 1'b0, failsafe_active);
    for (int c = 1; c < 4; c++) begin
      host_u.wr(WDOG_OFS, 8'(c << 4));
      repeat (WD_E[c] - 10) @(posedge ref_clk);
      #1;
      chk("wd early", 1'b0, failsafe_active);
      repeat (20) @(posedge ref_clk);
      #1;
      chk("wd expired", 1'b1, failsafe_active);
      host_u.wr(WDOG_OFS, 8'h00);
      host_u.wr(CLR_OFS, 8'h04);
    end
    host_u.wr(MASK_OFS, 8'h01);
    host_u.rd(STAT_OFS, d);
    host_u.wr(CLR_OFS, 8'h20);
    @(posedge ref_clk);
    #1;
    chk("irq entry", 1'b1, irq);
    host_u.rd(STAT_OFS, d);
    chk("status entry", 8'h01, d);
    host_u.wr(CLR_OFS, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq masked", 1'b0, irq);
    host_u.rd(STAT_OFS, d);
    chk("status exit", 8'h02, d);
    tally_and_finish();
  end
endmodule
